// >>> pkg/see_pkg.sv
// Shared constants, types and state codes for the serial EEPROM command engine.
// What this block does
// (R1) Acknowledge write select and both address bytes.
// (R2) Upper address byte first; extra bits ignored.
// (R3) Only stop in tenth slot starts programming.
// (R4) Counter points past last written byte.
// (R5) Busy programming: data line released, requests ignored.
// (R6) Protect high: no store, no program, no-acknowledge.
// (R7) Byte write acknowledged only when not inhibited.
// (R8) Page write takes 1 to 64 bytes.
// (R9) Page overflow wraps to page start.
// (R10) Counter advances after every written byte.
// (R11) Programming copies page latches into the array.
// (R12) Select refused while busy, accepted after.
// (R13) Reads ignore the protect input.
// (R14) Each completed read advances the counter.
// (R15) Random read: dummy write, restart, read one.
// (R16) Current read returns byte at counter.
// (R17) Acknowledged read byte brings the next one.
// (R18) Sequential read wraps after top to zero.
// (R19) Missing ninth-slot acknowledge ends the read.
// (R20) Array powers up with every byte erased.
// (R21) Select needs type and chip-select match.
// (R22) Protect high still acknowledges select and address.
// (R23) Receiver pulls line low in ninth slot.
// (R24) 16384 bytes, 64-byte pages, fourteen address bits.
// (R25) Programming time is a parameter, max 5 ms.
package see_pkg;
  localparam int ADDR_BITS = 14;
  localparam int PAGE_BITS = 6;
  localparam int MEM_BYTES = 16384;
  localparam int PAGE_BYTES = 64;
  // Device type identifier; the value is arbitrary.
  localparam logic [3:0] DEV_TYPE_ID = 4'h5;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int CLK_PERIOD_NS = 50;
  localparam int PROG_TIME_NS = 5000000;
  // Longest time, so the cycle count rounds down.
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  // Link-side protocol states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SELECT = 3'b001,
    ST_ADDR_HI = 3'b010,
    ST_ADDR_LO = 3'b011,
    ST_WR_DATA = 3'b100,
    ST_RD_DATA = 3'b101
  } see_state_e;
  // Programming sequencer states on the system clock.
  typedef enum logic [1:0] {
    PG_IDLE = 2'b00,
    PG_COPY = 2'b01,
    PG_WAIT = 2'b10
  } see_prog_e;
  // Layout of the select byte, first bit sent at the top.
  typedef struct packed {
    logic [3:0] devType;
    logic [2:0] chipSel;
    logic readNotWrite;
  } see_select_s;
  // Slow levels carried into the link domain together.
  typedef struct packed {
    logic writeProtect;
    logic [2:0] chipSelect;
    logic progBusy;
  } see_slow_s;
endpackage

// >>> rtl/see_eeprom_engine.sv
// Two-wire EEPROM slave: link protocol on the serial clock, array programming on the system clock.
`timescale 1ns/1ns
module see_eeprom_engine
  import see_pkg::*;
#(
  parameter int PROG_COUNT = PROG_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic writeProtect,
  input wire logic [2:0] chipSelect,
  output logic progBusy
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage.

  // The array; written only by the programming sequencer, read by the link.
  // It comes up erased by its declaration, so the write port stays its only driver.
  logic [7:0] memArray [MEM_BYTES] = '{default: ERASED_BYTE}; // R20
  // Page latches filled by the link during a write instruction.
  logic [7:0] pageLatch [PAGE_BYTES];
  // One bit per latch that holds a byte for the coming program cycle.
  logic [PAGE_BYTES-1:0] latchValid;

  ////////////////////////////////////////////////////////////////////////////
  // Start and stop detection, clocked by the data line itself.

  // Toggles once per start or stop seen while the serial clock is high.
  logic startTog;
  logic stopTog;
  // Whether the stop fell in the slot right after a data acknowledge.
  logic armedAtStop;
  // Set in the link domain during that slot.
  logic armed;
  // Set for the slot of a data byte's acknowledge, so armed follows one slot later.
  logic ackedData;

  // A falling data line with the clock high is a start.
  always_ff @(negedge sdaIn or negedge arst_n) begin
    if (!arst_n) begin
      startTog <= 1'b0;
    end else if (scl) begin
      startTog <= ~startTog;
    end
  end

  // A rising data line with the clock high is a stop; the slot is caught with it.
  always_ff @(posedge sdaIn or negedge arst_n) begin
    if (!arst_n) begin
      stopTog <= 1'b0;
      armedAtStop <= 1'b0;
    end else if (scl) begin
      stopTog <= ~stopTog;
      armedAtStop <= armed; // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slow levels into the link domain.

  // Three-stage chain; a bit moves only once stages two and three agree.
  see_slow_s slowS1;
  see_slow_s slowS2;
  see_slow_s slowS3;
  see_slow_s slowF;
  see_slow_s slowRaw;
  logic busyClk;

  assign slowRaw = '{writeProtect: writeProtect, chipSelect: chipSelect, progBusy: busyClk};

  // The link clock may stop between frames, so these lag until it runs again.
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      slowS1 <= '0;
      slowS2 <= '0;
      slowS3 <= '0;
      slowF <= '0;
    end else begin
      slowS1 <= slowRaw;
      slowS2 <= slowS1;
      slowS3 <= slowS2;
      slowF <= (slowS2 & slowS3) | (slowF & (slowS2 | slowS3));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link protocol, sampled on the rising serial clock.

  see_state_e state;
  see_state_e pendState;
  logic [3:0] bitCnt;
  logic [7:0] shReg;
  logic [7:0] txByte;
  logic ackFlag;
  logic [ADDR_BITS-1:0] addr;
  logic startSeen;

  // A start is pending when its toggle has not yet been taken here.
  // The toggle moved while the clock was high, a full low phase ago, so it is settled.
  logic startPend;
  logic byteDone;
  logic ackEdge;
  logic [7:0] rxByte;
  see_select_s selByte;
  logic selMatch;
  logic [ADDR_BITS-1:0] nextAddr;
  logic [PAGE_BITS-1:0] nextInPage;

  assign startPend = startTog ^ startSeen;
  assign byteDone = (bitCnt == LAST_DATA_BIT) && (state != ST_IDLE) && (state != ST_RD_DATA);
  assign ackEdge = (bitCnt == ACK_SLOT);
  assign rxByte = {shReg[6:0], sdaIn};
  assign selByte = see_select_s'(rxByte);
  // Busy refuses the select, which is what polling relies on.
  assign selMatch = (selByte.devType == DEV_TYPE_ID) && (selByte.chipSel == slowF.chipSelect)
    && !slowF.progBusy; // R21 R12 R5
  assign nextAddr = addr + 14'h1; // R18
  assign nextInPage = addr[PAGE_BITS-1:0] + 6'h1; // R9

  // Bit counter, shift register and start bookkeeping.
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      startSeen <= 1'b0;
      bitCnt <= 4'h0;
      shReg <= 8'h00;
      armed <= 1'b0;
      ackedData <= 1'b0;
    end else begin
      startSeen <= startTog;
      shReg <= rxByte;
      // The stop follows the next rising clock, so arming waits one slot past the acknowledge.
      ackedData <= (state == ST_WR_DATA) && ackEdge && !startPend; // R3
      armed <= ackedData && !startPend; // R3
      if (startPend) begin
        bitCnt <= 4'h1;
      end else if (ackEdge) begin
        bitCnt <= 4'h0;
      end else if (state != ST_IDLE) begin
        bitCnt <= bitCnt + 4'h1;
      end
    end
  end

  // Protocol state and acknowledge decision.
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      pendState <= ST_IDLE;
      ackFlag <= 1'b0;
    end else if (startPend) begin
      state <= ST_SELECT;
      ackFlag <= 1'b0;
    end else if (byteDone) begin
      case (state)
        // Select byte: direction picks the path, a mismatch goes to standby.
        ST_SELECT: begin
          ackFlag <= selMatch; // R1 R16
          if (!selMatch) begin
            pendState <= ST_IDLE;
          end else if (selByte.readNotWrite) begin
            pendState <= ST_RD_DATA;
          end else begin
            pendState <= ST_ADDR_HI;
          end
        end
        // Address bytes are taken even with writes protected.
        ST_ADDR_HI: begin
          ackFlag <= 1'b1; // R1 R22
          pendState <= ST_ADDR_LO;
        end
        ST_ADDR_LO: begin
          ackFlag <= 1'b1; // R1 R22
          pendState <= ST_WR_DATA;
        end
        // Data bytes are refused while the protect input is high.
        ST_WR_DATA: begin
          ackFlag <= !slowF.writeProtect; // R6 R7
          pendState <= ST_WR_DATA;
        end
        default: begin
          ackFlag <= 1'b0;
          pendState <= ST_IDLE;
        end
      endcase
    end else if (ackEdge) begin
      if (state == ST_RD_DATA) begin
        // A high line in the ninth slot ends the read.
        state <= sdaIn ? ST_IDLE : ST_RD_DATA; // R19 R17
      end else begin
        state <= pendState;
      end
      ackFlag <= 1'b0;
    end
  end

  // Address counter and byte to send; the protect input plays no part here.
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      addr <= '0;
      txByte <= 8'h00;
    end else if (!startPend && byteDone && state == ST_SELECT) begin
      txByte <= memArray[addr]; // R16 R13
    end else if (!startPend && byteDone && state == ST_ADDR_HI) begin
      // Bits above the array are dropped.
      addr[ADDR_BITS-1:8] <= rxByte[ADDR_BITS-9:0]; // R2 R24
    end else if (!startPend && byteDone && state == ST_ADDR_LO) begin
      addr[7:0] <= rxByte; // R2 R15
    end else if (!startPend && byteDone && state == ST_WR_DATA) begin
      // Advance within the page only; after the stop this points past the last byte.
      addr[PAGE_BITS-1:0] <= nextInPage; // R10 R9 R4
    end else if (!startPend && ackEdge && state == ST_RD_DATA) begin
      addr <= nextAddr; // R14 R18
      txByte <= memArray[nextAddr]; // R17
    end
  end

  // Page latches: cleared once the address is known, filled by accepted bytes.
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      latchValid <= '0;
    end else if (!startPend && byteDone && state == ST_ADDR_LO) begin
      latchValid <= '0;
    end else if (!startPend && byteDone && state == ST_WR_DATA && !slowF.writeProtect) begin
      latchValid[addr[PAGE_BITS-1:0]] <= 1'b1; // R8 R6
    end
  end

  // Latch data has no reset; validity lives in the mask above.
  always_ff @(posedge scl) begin
    if (!startPend && byteDone && state == ST_WR_DATA && !slowF.writeProtect) begin
      pageLatch[addr[PAGE_BITS-1:0]] <= rxByte; // R8 R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data line drive, changed on the falling serial clock.

  logic next_sdaOe;
  logic [2:0] txIdx;

  assign txIdx = LAST_DATA_BIT[2:0] - bitCnt[2:0];
  // Pull low for an acknowledge, or for a zero data bit while sending; never while busy.
  assign next_sdaOe = !slowF.progBusy && !startPend
    && ((ackEdge && ackFlag && state != ST_RD_DATA)
    || (state == ST_RD_DATA && bitCnt <= LAST_DATA_BIT && !txByte[txIdx])); // R23 R5

  // Open-drain: the output level is always low, only the enable moves.
  always_ff @(negedge scl or negedge arst_n) begin
    if (!arst_n) begin
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      sdaOe <= next_sdaOe;
      sdaOut <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programming sequencer on the system clock.

  // Stop toggle through three flip-flops; stages two and three differing is one stop.
  logic stopS1;
  logic stopS2;
  logic stopS3;
  logic stopEvt;
  see_prog_e progState;
  logic [PAGE_BITS-1:0] copyIdx;
  logic [31:0] waitCnt;
  logic [ADDR_BITS-1:0] copyAddr;
  logic progLaunch;

  assign stopEvt = stopS2 ^ stopS3;
  // Latches and flags are quiet here: the link stopped and is refused until done.
  assign progLaunch = stopEvt && armedAtStop && (|latchValid); // R3 R6
  assign copyAddr = {addr[ADDR_BITS-1:PAGE_BITS], copyIdx};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stopS1 <= 1'b0;
      stopS2 <= 1'b0;
      stopS3 <= 1'b0;
    end else begin
      stopS1 <= stopTog;
      stopS2 <= stopS1;
      stopS3 <= stopS2;
    end
  end

  // Copy the page one latch per cycle, then hold busy for the program time.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      progState <= PG_IDLE;
      copyIdx <= '0;
      waitCnt <= 32'h0;
      busyClk <= 1'b0;
    end else begin
      case (progState)
        PG_IDLE: begin
          if (progLaunch) begin
            progState <= PG_COPY;
            busyClk <= 1'b1; // R5
            copyIdx <= '0;
          end
        end
        PG_COPY: begin
          copyIdx <= copyIdx + 6'h1;
          if (copyIdx == 6'h3f) begin
            progState <= PG_WAIT;
            waitCnt <= 32'h0;
          end
        end
        PG_WAIT: begin
          waitCnt <= waitCnt + 32'h1;
          if (waitCnt == 32'(PROG_COUNT - 1)) begin
            progState <= PG_IDLE;
            busyClk <= 1'b0; // R25 R12
          end
        end
        default: begin
          progState <= PG_IDLE;
          busyClk <= 1'b0;
        end
      endcase
    end
  end

  // Array write port; only latches that received a byte are programmed.
  always_ff @(posedge clk) begin
    if (progState == PG_COPY && latchValid[copyIdx]) begin
      memArray[copyAddr] <= pageLatch[copyIdx]; // R11
    end
  end

  // Busy flag out, registered.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      progBusy <= 1'b0;
    end else begin
      progBusy <= busyClk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  // Ninth-slot acknowledge after a write select.
  sequence s_sel_write_done;
    state == ST_SELECT && byteDone && !startPend && selMatch && !selByte.readNotWrite;
  endsequence

  a_select_ack_write: assert property (@(posedge scl) disable iff (!arst_n) // R1
    s_sel_write_done |=> ackFlag && pendState == ST_ADDR_HI) else $error("write select not acknowledged");
  a_addr_ack_wp: assert property (@(posedge scl) disable iff (!arst_n) // R22
    (byteDone && !startPend && (state == ST_ADDR_HI || state == ST_ADDR_LO)) |=> ackFlag)
    else $error("address byte not acknowledged");
  a_wp_data_nack: assert property (@(posedge scl) disable iff (!arst_n) // R6
    (byteDone && !startPend && state == ST_WR_DATA && slowF.writeProtect) |=> !ackFlag && $stable(latchValid))
    else $error("protected data byte accepted");
  a_page_wrap_addr: assert property (@(posedge scl) disable iff (!arst_n) // R9
    (byteDone && !startPend && state == ST_WR_DATA) |=> addr[13:6] == $past(addr[13:6])
    && addr[5:0] == $past(addr[5:0]) + 6'h1) else $error("page address step wrong");
  a_read_addr_step: assert property (@(posedge scl) disable iff (!arst_n) // R14
    (ackEdge && !startPend && state == ST_RD_DATA) |=> addr == $past(addr) + 14'h1)
    else $error("read did not advance counter");
  a_read_nack_end: assert property (@(posedge scl) disable iff (!arst_n) // R19
    (ackEdge && !startPend && state == ST_RD_DATA && sdaIn) |=> state == ST_IDLE ##1 !sdaOe)
    else $error("read not ended on missing acknowledge");
  a_type_mismatch: assert property (@(posedge scl) disable iff (!arst_n) // R21
    (byteDone && !startPend && state == ST_SELECT && selByte.devType != DEV_TYPE_ID) |=> !ackFlag ##1 !sdaOe)
    else $error("foreign select acknowledged");
  a_busy_release: assert property (@(posedge scl) disable iff (!arst_n) // R5
    slowF.progBusy |-> !sdaOe) else $error("line driven while busy");
  a_stop_slot_only: assert property (@(posedge clk) disable iff (!arst_n) // R3
    (progState == PG_IDLE && stopEvt && !armedAtStop) |=> progState == PG_IDLE)
    else $error("program cycle started by misplaced stop");
  a_prog_launch: assert property (@(posedge clk) disable iff (!arst_n) // R11
    (progState == PG_IDLE && progLaunch) |=> busyClk && progState == PG_COPY ##64 progState == PG_WAIT)
    else $error("program cycle did not run its copy");
  a_prog_wait_bound: assert property (@(posedge clk) disable iff (!arst_n) // R25
    progState == PG_WAIT |-> waitCnt < 32'(PROG_COUNT)) else $error("program wait overran");

endmodule

// >>> verif/see_bus_master.sv
// Bus master model that bit-bangs two-wire frames towards the EEPROM engine.
`timescale 1ns/1ns
module see_bus_master #(
  parameter int QUARTER = 20
) (
  output logic scl,
  output logic masterOe,
  input wire logic sdaIn
);
  // The clock stands high and the line is released outside frames.
  initial begin
    scl = 1'b1;
    masterOe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Idle clocks let the engine's filtered copies of the straps settle.
  task automatic idleClocks(input int n);
    repeat (n) begin
      #(2 * QUARTER) scl = 1'b0;
      #(2 * QUARTER) scl = 1'b1;
    end
  endtask

  // Start or repeated start: the line falls while the clock is high.
  task automatic start();
    #(QUARTER) masterOe = 1'b0;
    #(QUARTER) scl = 1'b1;
    #(QUARTER) masterOe = 1'b1;
    #(QUARTER) scl = 1'b0;
  endtask

  // Stop: the line rises while the clock is high.
  task automatic stop();
    #(QUARTER) masterOe = 1'b1;
    #(QUARTER) scl = 1'b1;
    #(QUARTER) masterOe = 1'b0;
    #(QUARTER);
  endtask

  // One bit sent; the line only changes while the clock is low.
  task automatic bitOut(input logic b);
    #(QUARTER) masterOe = ~b;
    #(QUARTER) scl = 1'b1;
    #(2 * QUARTER) scl = 1'b0;
  endtask

  // One bit received, sampled in the middle of the high phase.
  task automatic bitIn(output logic v);
    #(QUARTER) masterOe = 1'b0;
    #(QUARTER) scl = 1'b1;
    #(QUARTER) v = sdaIn;
    #(QUARTER) scl = 1'b0;
  endtask

  // A byte sent top bit first, then the ninth slot read as acknowledge.
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bitOut(b[i]);
    end
    bitIn(v);
    ack = ~v;
  endtask

  // A byte received, then acknowledged or left high in the ninth slot.
  task automatic recvByte(input logic ackIt, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bitIn(d[i]);
    end
    bitOut(~ackIt);
  endtask
endmodule

// >>> verif/see_eeprom_engine_tb_top.sv
// Testbench top: drives the EEPROM engine through the master model and checks every reply except the acknowledges of a random read's address header.
`timescale 1ns/1ns
module see_eeprom_engine_tb_top;
  import see_pkg::*;
  localparam int PROG_SHORT = 20; // Short programming wait keeps the run brief.
  logic clk = 1'b0;
  logic arst_n; // Driven low at time zero so every reset branch sees an edge.
  logic writeProtect = 1'b0;
  logic [2:0] chipSelect = 3'h0;
  logic [2:0] cs;
  wire scl;
  wire masterOe;
  logic sdaOut;
  logic sdaOe;
  logic progBusy;
  logic sawBusy = 1'b0; // Set whenever a programming cycle is seen.
  logic [7:0] refMem [MEM_BYTES]; // Expected array contents.
  logic [13:0] ptr; // Expected address counter.
  int errors = 0;
  int checks = 0;
  int counts [4];
  // Open-drain wire with pull-up: low if either party pulls it.
  wire sdaIn = ~(sdaOe | masterOe);

  see_eeprom_engine #(.PROG_COUNT(PROG_SHORT)) i_see_eeprom_engine (.clk(clk), .arst_n(arst_n), .scl(scl),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .writeProtect(writeProtect), .chipSelect(chipSelect),
    .progBusy(progBusy));
  see_bus_master i_see_bus_master (.scl(scl), .masterOe(masterOe), .sdaIn(sdaIn));

  always #25 clk = ~clk;
  // Latch any programming activity so short pulses are not missed.
  always @(posedge clk) if (progBusy === 1'b1) sawBusy = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmpBit(input string what, input logic exp, input logic seen);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic cmpByte(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Select byte: type identifier, chip-select field, direction.
  function automatic logic [7:0] selByte(input logic rd, input logic [2:0] c);
    return {DEV_TYPE_ID, c, rd};
  endfunction

  // Poll until acknowledged, then stop early so no second cycle starts.
  task automatic pollReady();
    logic ack;
    int tries;
    ack = 1'b0;
    tries = 0;
    while (ack !== 1'b1 && tries < 60) begin
      i_see_bus_master.start();
      i_see_bus_master.sendByte(selByte(1'b0, cs), ack);
      if (tries == 0) cmpBit("select while busy", 1'b0, ack);
      if (ack !== 1'b1) i_see_bus_master.stop();
      tries++;
    end
    cmpBit("poll ack", 1'b1, ack);
    cmpBit("program cycle ran", 1'b1, sawBusy);
    sawBusy = 1'b0;
    i_see_bus_master.stop();
    repeat (150) @(posedge clk);
    cmpBit("busy after early stop", 1'b0, sawBusy);
  endtask

  // Write header, n random data bytes, stop; protected writes must be refused.
  task automatic writeSeq(input logic [15:0] addr, input int n, input logic prot);
    logic ack;
    logic [7:0] d;
    logic [13:0] a;
    a = addr[13:0];
    i_see_bus_master.start();
    i_see_bus_master.sendByte(selByte(1'b0, cs), ack);
    cmpBit("write select ack", 1'b1, ack);
    i_see_bus_master.sendByte(addr[15:8], ack);
    cmpBit("upper address ack", 1'b1, ack);
    i_see_bus_master.sendByte(addr[7:0], ack);
    cmpBit("lower address ack", 1'b1, ack);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      i_see_bus_master.sendByte(d, ack);
      cmpBit("data ack", ~prot, ack);
      if (!prot) refMem[a] = d;
      a = {a[13:6], 6'(a[5:0] + 6'h01)};
    end
    sawBusy = 1'b0;
    i_see_bus_master.stop();
    ptr = a;
    if (prot) begin
      repeat (200) @(posedge clk);
      cmpBit("busy after protected write", 1'b0, sawBusy);
    end else begin
      pollReady();
    end
  endtask

  // Random or current read of n bytes, the last one not acknowledged.
  task automatic readSeq(input logic [15:0] addr, input logic rnd, input int n);
    logic ack;
    logic [7:0] d;
    logic v;
    if (rnd) begin
      i_see_bus_master.start();
      i_see_bus_master.sendByte(selByte(1'b0, cs), ack);
      i_see_bus_master.sendByte(addr[15:8], ack);
      i_see_bus_master.sendByte(addr[7:0], ack);
      ptr = addr[13:0];
    end
    i_see_bus_master.start();
    i_see_bus_master.sendByte(selByte(1'b1, cs), ack);
    cmpBit("read select ack", 1'b1, ack);
    cmpBit("open-drain level", 1'b0, sdaOut);
    for (int i = 0; i < n; i++) begin
      i_see_bus_master.recvByte(i < n - 1, d);
      cmpByte("read data", refMem[ptr], d);
      ptr = ptr + 14'h0001;
    end
    // After the refused byte the line must stay released.
    i_see_bus_master.bitIn(v);
    cmpBit("line after no acknowledge", 1'b1, v);
    i_see_bus_master.stop();
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: erased reads, refused selects, page writes, protection, wrap.
  initial begin
    logic ack;
    logic [15:0] addr;
    arst_n <= 1'b0;
    void'($urandom(32'hc711));
    foreach (refMem[i]) refMem[i] = ERASED_BYTE;
    cs = 3'($urandom);
    @(posedge clk);
    chipSelect <= cs;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    i_see_bus_master.idleClocks(4);
    readSeq(16'($urandom), 1'b1, 2);
    // A wrong type and a wrong chip select must both be ignored.
    for (int k = 0; k < 2; k++) begin
      i_see_bus_master.start();
      i_see_bus_master.sendByte(k == 0 ? {DEV_TYPE_ID ^ 4'($urandom_range(15, 1)), cs, 1'b0} :
        selByte(1'b0, cs ^ 3'($urandom_range(7, 1))), ack);
      cmpBit("foreign select ack", 1'b0, ack);
      i_see_bus_master.stop();
    end
    // Page writes of one byte, a full page, an overflow and a random count.
    counts = '{1, 64, 66, 0};
    counts[3] = $urandom_range(63, 2);
    foreach (counts[k]) begin
      addr = 16'($urandom);
      writeSeq(addr, counts[k], 1'b0);
      readSeq(16'h0000, 1'b0, 1);
      readSeq({addr[15:6], 6'h00}, 1'b1, 64);
    end
    // Protected write leaves the array alone; reads still work.
    @(posedge clk);
    writeProtect <= 1'b1;
    writeSeq(addr, 3, 1'b1);
    readSeq(addr, 1'b1, 3);
    @(posedge clk);
    writeProtect <= 1'b0;
    readSeq(16'h3ffe, 1'b1, 3);
    summarize();
  end

  // Watchdog: far beyond the expected run of about half a millisecond.
  initial begin
    #3000000;
    errors++;
    summarize();
  end
endmodule
